// ==== mie_core.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Add-with-carry sums A, operand and C; C is the carry out.
// - Subtract-with-borrow takes A minus operand minus not C; C is not-borrow.
// - Immediate add and subtract use the literal, same carry, one cycle.
// - A result written to data RAM costs one extra cycle; system registers none.
// - A taken skip costs one extra cycle; an untaken one costs nothing.
// - Compare subtracts without storing, updates Z and C, skips when equal.
// - Increment or decrement memory, store to A or M, skip on zero, flags kept.
// - Bit test skips on a clear bit or on a set bit, flags kept.
// - Jump loads PC low fourteen bits from operand, top two from page select.
// - Call pushes full PC plus one then jumps; return pops; both take two cycles.
// - Interrupt return pops PC and sets the global interrupt enable, two cycles.
// - Context save and restore of A and flags in one cycle, cause bits excluded.
// - Bank-zero move of a literal only writes targets 0x80 to 0x87.
// - Bank-zero forms address bank 0 whatever the bank select holds.
// - Nibble swap exchanges halves into A or back into M, flags kept.
module mie_core (
    // Clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_rst_b,
    // Program memory
    output logic [15:0]                     o_pc,
    output logic                            o_fetch,
    input  mie_pkg::mie_instr_t             i_instr,
    // Data memory and system registers
    output logic [mie_pkg::ADDR_W-1:0]      o_mem_raddr,
    input  wire logic [7:0]                 i_mem_rdata,
    output logic                            o_mem_we,
    output logic [mie_pkg::ADDR_W-1:0]      o_mem_waddr,
    output logic [7:0]                      o_mem_wdata,
    // Core control
    input  wire logic [mie_pkg::BANK_W-1:0] i_ram_bank,
    input  wire logic [1:0]                 i_rom_page,
    input  wire logic [1:0]                 i_reset_cause,
    input  wire logic                       i_gie_clear,
    output logic [7:0]                      o_acc,
    output logic [7:0]                      o_program_flag_register,
    output logic                            o_gie
);
    import mie_pkg::*;

    mie_core_t         q;
    mie_core_t         d;
    mie_alu_t          alu;
    mie_instr_t        ins;
    logic [BANK_W-1:0] bank;
    logic              is_sys;
    logic              exec;
    logic              wr_acc;
    logic              wr_mem;
    logic              skip;
    logic              br;
    logic              push;
    logic              pop;
    logic [15:0]       stk_top;

    assign ins  = i_instr;
    assign exec = (q.st == ST_EXEC);
    assign bank = ins.bank0 ? '0 : i_ram_bank;
    // Only bank 0 maps system registers at the top of its page
    assign is_sys = (bank == '0) && (ins.addr >= SYS_BASE);

    mie_alu u_alu (
        .i_instr (ins),
        .i_acc   (q.acc),
        .i_mem   (i_mem_rdata),
        .i_carry (q.program_flag_register[FLAG_C]),
        .o_alu   (alu)
    );

    mie_stack #(
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_push  (push),
        .i_pop   (pop),
        .i_data  (q.pc + 16'h0001),
        .o_top   (stk_top)
    );

    always_comb begin
        d        = q;
        wr_acc   = 1'b0;
        wr_mem   = 1'b0;
        skip     = 1'b0;
        br       = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        d.wr.we  = 1'b0;
        d.program_flag_register[CAUSE_HI:CAUSE_LO] = i_reset_cause;
        if (i_gie_clear) begin
            d.gie = 1'b0;
        end
        case (q.st)
            ST_EXEC: begin
                d.pc = q.pc + 16'h0001;
                if (mie_has_result(ins.op)) begin
                    wr_acc = !ins.to_mem;
                    wr_mem = ins.to_mem;
                end
                case (ins.op)
                    OP_MOV: begin
                        if (ins.to_mem && ins.use_imm &&
                            (ins.addr < BZ_IMM_LO || ins.addr > BZ_IMM_HI ||
                             bank != '0)) begin
                            wr_mem = 1'b0;
                        end
                    end
                    OP_XCH: begin
                        d.acc  = i_mem_rdata;
                        wr_mem = 1'b1;
                    end
                    OP_CLR, OP_BCLR, OP_BSET: wr_mem = 1'b1;
                    OP_CMP:  skip = alu.z;
                    OP_INCS, OP_DECS: skip = alu.z;
                    OP_BIT_TEST_SKIP_CLEAR: skip = !i_mem_rdata[ins.bit_sel];
                    OP_BIT_TEST_SKIP_SET: skip = i_mem_rdata[ins.bit_sel];
                    OP_JMP: begin
                        d.pc = {i_rom_page, ins.target};
                        br   = 1'b1;
                    end
                    OP_CALL: begin
                        push = 1'b1;
                        d.pc = {i_rom_page, ins.target};
                        br   = 1'b1;
                    end
                    OP_RET, OP_INTERRUPT_RETURN: begin
                        pop  = 1'b1;
                        d.pc = stk_top;
                        br   = 1'b1;
                        if (ins.op == OP_INTERRUPT_RETURN) begin
                            d.gie = 1'b1;
                        end
                    end
                    OP_PUSH: begin
                        d.acc_buf  = q.acc;
                        d.flag_buf = q.program_flag_register[2:0];
                    end
                    OP_POP: begin
                        d.acc        = q.acc_buf;
                        d.program_flag_register[2:0] = q.flag_buf;
                    end
                    default: ;
                endcase
                if (wr_acc) begin
                    d.acc = alu.res;
                end
                if (alu.upd_c) begin
                    d.program_flag_register[FLAG_C] = alu.c;
                end
                if (alu.upd_dc) begin
                    d.program_flag_register[FLAG_DC] = alu.dc;
                end
                if (alu.upd_z) begin
                    d.program_flag_register[FLAG_Z] = alu.z;
                end
                if (wr_mem) begin
                    d.wr.we   = 1'b1;
                    d.wr.addr = {bank, ins.addr};
                    d.wr.data = alu.res;
                end
                d.skip_pend = skip;
                if (wr_mem && !is_sys) begin
                    d.st = ST_WB;
                end else if (br) begin
                    d.st = ST_BR2;
                end else if (skip) begin
                    d.st = ST_SKIP;
                end else begin
                    d.st = ST_EXEC;
                end
            end
            ST_WB: d.st = q.skip_pend ? ST_SKIP : ST_EXEC;
            ST_BR2: d.st = ST_EXEC;
            ST_SKIP: begin
                // The fetched word is dropped; only the PC moves on
                d.pc = q.pc + 16'h0001;
                d.st = ST_EXEC;
            end
            default: d.st = ST_EXEC;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q       <= '0;
            q.st    <= ST_EXEC;
            q.pc    <= PC_RST;
            q.acc   <= ACC_RST;
            q.program_flag_register <= PROGRAM_FLAG_REGISTER_RST;
        end else begin
            q <= d;
        end
    end

    // A system register written by one instruction is read stale by
    // the very next one; the write lands a cycle after execution.
    assign o_pc        = q.pc;
    assign o_fetch     = exec;
    assign o_mem_raddr = {bank, ins.addr};
    assign o_mem_we    = q.wr.we;
    assign o_mem_waddr = q.wr.addr;
    assign o_mem_wdata = q.wr.data;
    assign o_acc       = q.acc;
    assign o_program_flag_register     = q.program_flag_register;
    assign o_gie       = q.gie;

    // Checking helpers
    logic [7:0] h_opnd;
    logic [8:0] h_adc;
    logic       h_nb;
    logic [15:0] h_jt;
    assign h_opnd = ins.use_imm ? ins.imm : i_mem_rdata;
    assign h_adc  = {1'b0, q.acc} + {1'b0, h_opnd} + {8'h00, q.program_flag_register[FLAG_C]};
    assign h_nb   = {1'b0, q.acc} >=
                    ({1'b0, h_opnd} + {8'h00, !q.program_flag_register[FLAG_C]});
    assign h_jt   = {i_rom_page, ins.target};

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    sequence s_skip_tail;
        q.st == ST_SKIP ##1 q.st == ST_EXEC;
    endsequence
    sequence s_branch_tail;
        q.st == ST_BR2 ##1 q.st == ST_EXEC;
    endsequence

    a_adc_carry: assert property (
        exec && ins.op == OP_ADC |=> q.program_flag_register[FLAG_C] == $past(h_adc[8])
    ) else $error("add-with-carry flag wrong");
    a_sbc_borrow: assert property (
        exec && ins.op == OP_SBC |=> q.program_flag_register[FLAG_C] == $past(h_nb)
    ) else $error("subtract not-borrow flag wrong");
    a_imm_single: assert property (
        exec && ins.use_imm && (ins.op == OP_ADD || ins.op == OP_SUB)
        |=> o_fetch && q.acc == $past(alu.res)
    ) else $error("immediate arithmetic not one cycle");
    a_ram_extra: assert property (
        exec && wr_mem && !is_sys |=> q.st == ST_WB && o_mem_we ##1 !o_mem_we
    ) else $error("RAM write-back cycle missing");
    a_sys_direct: assert property (
        exec && wr_mem && is_sys && !skip |=> o_fetch && o_mem_we
    ) else $error("system register write took extra cycle");
    a_skip_cycle: assert property (
        exec && skip && !wr_mem |=> s_skip_tail
    ) else $error("taken skip not one extra cycle");
    a_cmp_equal: assert property (
        exec && ins.op == OP_CMP
        |=> (q.st == ST_SKIP) == ($past(q.acc) == $past(h_opnd))
    ) else $error("compare skip mismatch");
    a_incs_flags: assert property (
        exec && (ins.op == OP_INCS || ins.op == OP_DECS)
        |=> $stable(q.program_flag_register[2:0])
    ) else $error("increment-skip changed flags");
    a_bts_skip: assert property (
        exec && ins.op == OP_BIT_TEST_SKIP_SET
        |=> (q.st == ST_SKIP) == $past(i_mem_rdata[ins.bit_sel])
    ) else $error("bit test skip mismatch");
    a_jump_target: assert property (
        exec && ins.op == OP_JMP |=> q.pc == $past(h_jt) ##0 s_branch_tail
    ) else $error("jump target or timing wrong");
    a_call_push: assert property (
        exec && ins.op == OP_CALL |=> stk_top == $past(q.pc) + 16'h0001
    ) else $error("call did not push return address");
    a_interrupt_return_gie: assert property (
        exec && ins.op == OP_INTERRUPT_RETURN && !i_gie_clear |=> q.gie ##1 o_fetch
    ) else $error("interrupt return missed enable");
    a_ctx_save: assert property (
        exec && ins.op == OP_PUSH
        |=> q.acc_buf == $past(q.acc) && q.flag_buf == $past(q.program_flag_register[2:0])
    ) else $error("context save wrong");
    a_bz_range: assert property (
        exec && ins.op == OP_MOV && ins.use_imm && ins.to_mem &&
        ins.addr > BZ_IMM_HI |=> !o_mem_we
    ) else $error("literal write outside allowed range");
    a_bank_zero: assert property (
        ins.bank0 |-> o_mem_raddr[ADDR_W-1:8] == '0
    ) else $error("bank-zero form left bank 0");
    a_swap_nib: assert property (
        exec && ins.op == OP_SWAP && !ins.to_mem
        |=> q.acc == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])}
    ) else $error("nibble swap wrong");
    a_zero_flag: assert property (
        exec && ins.op == OP_SUB && !ins.to_mem
        |=> q.program_flag_register[FLAG_Z] == (q.acc == 8'h00)
    ) else $error("zero flag wrong");
    a_skip_quiet: assert property (
        q.st == ST_SKIP |=> !o_mem_we && $stable(q.acc) && $stable(q.program_flag_register)
    ) else $error("skipped instruction had effect");

endmodule : mie_core

// ==== mie_pkg.sv ====
package mie_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W   = 16;
    localparam int JMP_W  = 14;
    localparam int BANK_W = 1;
    localparam int ADDR_W = BANK_W + 8;

    localparam logic [7:0] SYS_BASE  = 8'h80;
    localparam logic [7:0] BZ_IMM_LO = 8'h80;
    localparam logic [7:0] BZ_IMM_HI = 8'h87;

    // Flag register layout
    localparam int FLAG_Z     = 0;
    localparam int FLAG_DC    = 1;
    localparam int FLAG_C     = 2;
    localparam int CAUSE_LO   = 6;
    localparam int CAUSE_HI   = 7;

    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [7:0]  PROGRAM_FLAG_REGISTER_RST = 8'h00;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam int          STACK_DEPTH = 8;

    typedef enum logic [4:0] {
        OP_NOP, OP_MOV, OP_XCH, OP_ADC, OP_ADD, OP_SBC, OP_SUB,
        OP_AND, OP_OR, OP_XOR, OP_SWAP, OP_RRC, OP_RLC, OP_CLR,
        OP_BCLR, OP_BSET, OP_CMP, OP_INCS, OP_DECS, OP_BIT_TEST_SKIP_CLEAR,
        OP_BIT_TEST_SKIP_SET, OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN, OP_PUSH, OP_POP
    } mie_op_t;

    typedef enum logic [1:0] {
        ST_EXEC, ST_WB, ST_BR2, ST_SKIP
    } mie_state_t;

    typedef struct packed {
        mie_op_t     op;
        logic        to_mem;
        logic        use_imm;
        logic        bank0;
        logic [7:0]  addr;
        logic [2:0]  bit_sel;
        logic [7:0]  imm;
        logic [13:0] target;
    } mie_instr_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       dc;
        logic       z;
        logic       upd_c;
        logic       upd_dc;
        logic       upd_z;
    } mie_alu_t;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } mie_wr_t;

    typedef struct packed {
        mie_state_t  st;
        logic [15:0] pc;
        logic [7:0]  acc;
        logic [7:0]  program_flag_register;
        logic [7:0]  acc_buf;
        logic [2:0]  flag_buf;
        logic        gie;
        logic        skip_pend;
        mie_wr_t     wr;
    } mie_core_t;

    // Ops whose ALU result lands in A or M under the to_mem bit
    function automatic logic mie_has_result(input mie_op_t op);
        case (op)
            OP_MOV, OP_ADC, OP_ADD, OP_SBC, OP_SUB, OP_AND, OP_OR,
            OP_XOR, OP_SWAP, OP_RRC, OP_RLC, OP_INCS,
            OP_DECS: mie_has_result = 1'b1;
            default: mie_has_result = 1'b0;
        endcase
    endfunction : mie_has_result

endpackage : mie_pkg

// ==== mie_alu.sv ====
`timescale 1ns/1ps
module mie_alu (
    // Operands
    input  mie_pkg::mie_instr_t i_instr,
    input  wire logic [7:0]     i_acc,
    input  wire logic [7:0]     i_mem,
    input  wire logic           i_carry,
    // Result and flag effects
    output mie_pkg::mie_alu_t   o_alu
);
    import mie_pkg::*;

    logic [7:0] opnd;
    logic [7:0] addend;
    logic [8:0] sum;
    logic [4:0] half;
    logic       sub;
    logic       cin;

    always_comb begin
        opnd   = i_instr.use_imm ? i_instr.imm : i_mem;
        sub    = (i_instr.op == OP_SBC) || (i_instr.op == OP_SUB) ||
                 (i_instr.op == OP_CMP);
        // Subtract is add of the inverse; carry out is then not-borrow
        cin    = ((i_instr.op == OP_ADC) || (i_instr.op == OP_SBC)) ?
                 i_carry : sub;
        addend = sub ? ~opnd : opnd;
        sum    = {1'b0, i_acc} + {1'b0, addend} + {8'h00, cin};
        half   = {1'b0, i_acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        o_alu  = '0;
        case (i_instr.op)
            OP_ADC, OP_ADD, OP_SBC, OP_SUB, OP_CMP: begin
                o_alu.res    = sum[7:0];
                o_alu.c      = sum[8];
                o_alu.dc     = half[4];
                o_alu.upd_c  = 1'b1;
                o_alu.upd_dc = !(i_instr.op == OP_CMP);
                o_alu.upd_z  = 1'b1;
            end
            OP_AND: begin
                o_alu.res   = i_acc & opnd;
                o_alu.upd_z = 1'b1;
            end
            OP_OR: begin
                o_alu.res   = i_acc | opnd;
                o_alu.upd_z = 1'b1;
            end
            OP_XOR: begin
                o_alu.res   = i_acc ^ opnd;
                o_alu.upd_z = 1'b1;
            end
            OP_MOV: begin
                if (i_instr.to_mem) begin
                    o_alu.res = i_instr.use_imm ? i_instr.imm : i_acc;
                end else begin
                    o_alu.res   = opnd;
                    o_alu.upd_z = !i_instr.use_imm;
                end
            end
            OP_SWAP: o_alu.res = {i_mem[3:0], i_mem[7:4]};
            OP_RRC: begin
                o_alu.res   = {i_carry, i_mem[7:1]};
                o_alu.c     = i_mem[0];
                o_alu.upd_c = 1'b1;
            end
            OP_RLC: begin
                o_alu.res   = {i_mem[6:0], i_carry};
                o_alu.c     = i_mem[7];
                o_alu.upd_c = 1'b1;
            end
            OP_INCS: o_alu.res = i_mem + 8'h01;
            OP_DECS: o_alu.res = i_mem - 8'h01;
            OP_CLR:  o_alu.res = 8'h00;
            OP_BCLR: o_alu.res = i_mem & ~(8'h01 << i_instr.bit_sel);
            OP_BSET: o_alu.res = i_mem | (8'h01 << i_instr.bit_sel);
            default: o_alu.res = i_acc;
        endcase
        o_alu.z = (o_alu.res == 8'h00);
    end

endmodule : mie_alu

// ==== mie_stack.sv ====
`timescale 1ns/1ps
module mie_stack #(
    parameter int DEPTH = mie_pkg::STACK_DEPTH
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    // Push and pop
    input  wire logic        i_push,
    input  wire logic        i_pop,
    input  wire logic [15:0] i_data,
    output logic [15:0]      o_top
);
    import mie_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("Stack depth must be a power of two, two or more");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][15:0] mem;
        logic [PTR_W-1:0]       ptr;
    } mie_stk_t;

    mie_stk_t q;
    mie_stk_t d;

    // Pointer wraps; overflow silently overwrites the oldest entry
    always_comb begin
        d = q;
        if (i_push) begin
            d.mem[q.ptr] = i_data;
            d.ptr        = q.ptr + PTR_W'(1);
        end else if (i_pop) begin
            d.ptr = q.ptr - PTR_W'(1);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_top = q.mem[q.ptr - PTR_W'(1)];

endmodule : mie_stack

// ==== mie_mem_model.sv ====
`timescale 1ns/1ps
module mie_mem_model (
    // Clock
    input  wire logic           i_clock,
    // Program memory
    input  wire logic [15:0]    i_pc,
    output mie_pkg::mie_instr_t o_instr,
    // Data memory and system registers
    input  wire logic [8:0]     i_raddr,
    output logic [7:0]          o_rdata,
    input  wire logic           i_we,
    input  wire logic [8:0]     i_waddr,
    input  wire logic [7:0]     i_wdata
);
    import mie_pkg::*;
    // Only the low eight PC bits decode; the bench checks the page bits itself
    mie_instr_t prog [256];
    logic [7:0] ram  [512];
    assign o_instr = prog[i_pc[7:0]];
    assign o_rdata = ram[i_raddr];
    always @(posedge i_clock) begin
        if (i_we) begin
            ram[i_waddr] <= i_wdata;
        end
    end
endmodule : mie_mem_model

// ==== mie_core_tb_top.sv ====
`timescale 1ns/1ps
module mie_core_tb_top;
    import mie_pkg::*;
    typedef struct packed {
        logic [8:0]  a;
        logic [7:0]  d;
        logic [7:0]  f;
        logic        g;
        logic [1:0]  p;
        logic [15:0] t;
    } mie_note_t;
    logic        i_clock = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [1:0]  cause;
    mie_instr_t  instr;
    logic [8:0]  raddr;
    logic [7:0]  rdata;
    logic [15:0] pc;
    logic        mem_we;
    logic [8:0]  waddr;
    logic [7:0]  wdata;
    logic [7:0]  program_flag_register;
    logic        gie;
    logic        fetch;
    logic        f0;
    logic [7:0]  acc;
    mie_note_t   notes [$];
    mie_note_t   seen;
    int          num_errors = 0;
    int          checks_done = 0;
    logic [15:0] cyc = 16'h0000;
    logic [7:0]  pcl, ac, sv, x, y, m, r, i;
    logic        c, dc, z, e_gie;
    logic [2:0]  fl;
    logic [1:0]  e_pg;
    int          t, k;

    always #10 i_clock = ~i_clock;

    mie_core dut (
        .i_clock       (i_clock),
        .i_rst_b       (i_rst_b),
        .o_pc          (pc),
        .o_fetch       (fetch),
        .i_instr       (instr),
        .o_mem_raddr   (raddr),
        .i_mem_rdata   (rdata),
        .o_mem_we      (mem_we),
        .o_mem_waddr   (waddr),
        .o_mem_wdata   (wdata),
        .i_ram_bank    (1'b1),
        .i_rom_page    (2'b10),
        .i_reset_cause (cause),
        .i_gie_clear   (1'b0),
        .o_acc         (acc),
        .o_program_flag_register       (program_flag_register),
        .o_gie         (gie)
    );

    mie_mem_model mem (
        .i_clock (i_clock),
        .i_pc    (pc),
        .o_instr (instr),
        .i_raddr (raddr),
        .o_rdata (rdata),
        .i_we    (mem_we),
        .i_waddr (waddr),
        .i_wdata (wdata)
    );

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    function automatic logic [9:0] alu(input logic [7:0] a,
                                       input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] l;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {s[8], l[4], s[7:0]};
    endfunction : alu

    // Program words go in execution order; t tracks the executing edge
    task automatic put(input mie_op_t op, input logic [2:0] f,
                       input logic [7:0] a, input logic [7:0] im, input int n);
        mem.prog[pcl] = '{op, f[2], f[1], f[0], a, im[2:0], im, {a[5:0], im}};
        pcl = pcl + 8'h01;
        t = t + n;
    endtask : put

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        notes.push_back('{a, d, {cause, 3'b000, c, dc, z}, e_gie, e_pg,
                          16'(t + 1)});
    endtask : wr

    task automatic sto(input logic b0, input logic [7:0] a);
        wr({~b0, a}, ac);
        put(OP_MOV, {2'b10, b0}, a, 8'h00, (b0 && a[7]) ? 1 : 2);
    endtask : sto

    task automatic arith(input logic [7:0] b, input logic ci);
        {c, dc, ac} = alu(ac, b, ci);
        z = (ac == 8'h00);
    endtask : arith

    // A dropped word would write 0x30 and show as an unexpected write
    task automatic tail(input logic s);
        if (s) put(OP_MOV, 3'b100, 8'h30, 8'h00, 0);
    endtask : tail

    task automatic cmp(input logic [7:0] im);
        logic [7:0] q;
        logic       d;
        {c, d, q} = alu(ac, ~im, 1'b1);
        z = (q == 8'h00);
        put(OP_CMP, 3'b010, 8'h00, im, z ? 2 : 1);
        tail(z);
    endtask : cmp

    task automatic memop(input mie_op_t op, input logic [2:0] f,
                         input logic [7:0] a, input logic [7:0] im,
                         input logic [7:0] mv, input logic [7:0] rv,
                         input logic s);
        logic [8:0] ad;
        ad = {~f[0], a};
        mem.ram[ad] = mv;
        if (f[2]) wr(ad, rv);
        else ac = rv;
        put(op, f, a, im, 1 + int'(f[2] && ad[8:7] != 2'b01) + int'(s));
        tail(s);
    endtask : memop

    always @(posedge i_clock) begin
        if (i_rst_b === 1'b1) begin
            if (mem_we === 1'b1) begin
                seen = '{waddr, wdata, program_flag_register, gie, pc[15:14], cyc};
                if (notes.size() == 0) check(64'h1, 64'h0);
                else check(64'(seen), 64'(notes.pop_front()));
            end
            cyc = cyc + 16'h0001;
        end
    end

    initial begin
        cause = 2'($urandom(81405));
        foreach (mem.prog[n]) mem.prog[n] = '0;
        foreach (mem.ram[n]) mem.ram[n] = 8'h00;
        {pcl, t, e_pg, e_gie, c, dc, z, ac} = '0;
        put(OP_JMP, 3'b000, 8'h00, 8'h02, 2);
        pcl = 8'h02;
        e_pg = 2'b10;
        for (i = 8'h00; i < 8'h08; i++) begin
            x = 8'($urandom);
            y = 8'($urandom);
            m = 8'($urandom);
            put(OP_MOV, 3'b010, 8'h00, x, 1);
            ac = x;
            put(OP_ADD, 3'b010, 8'h00, y, 1);
            arith(y, 1'b0);
            sto(1'b0, 8'h10 + i);
            mem.ram[{1'b1, 8'h40 + i}] = m;
            put(OP_ADC, 3'b000, 8'h40 + i, 8'h00, 1);
            arith(m, c);
            sto(1'b1, 8'h90 + i);
            mem.ram[{1'b1, 8'h50 + i}] = y;
            sv = ac;
            arith(~y, c);
            wr({1'b1, 8'h50 + i}, ac);
            ac = sv;
            put(OP_SBC, 3'b100, 8'h50 + i, 8'h00, 2);
            put(OP_SUB, 3'b010, 8'h00, m, 1);
            arith(~m, 1'b1);
            cmp(ac);
            cmp(x);
            sto(1'b0, 8'h20 + i);
            if (i < 8'h04) m = i[0] ? 8'hff : 8'h01;
            r = i[0] ? m + 8'h01 : m - 8'h01;
            memop(i[0] ? OP_INCS : OP_DECS, {i[1], 1'b0, i[2]}, 8'h60 + i,
                  8'h00, m, r, r == 8'h00);
            memop(OP_SWAP, {i[0], 2'b00}, 8'he0 + i, 8'h00, y,
                  {y[3:0], y[7:4]}, 1'b0);
            memop(OP_BIT_TEST_SKIP_CLEAR, 3'b000, 8'hb0 + i, {5'h00, x[2:0]}, m, ac,
                  ~m[x[2:0]]);
            memop(OP_BIT_TEST_SKIP_SET, 3'b000, 8'hb8 + i, {5'h00, y[2:0]}, y, ac,
                  y[y[2:0]]);
            sto(1'b0, 8'ha0 + i);
        end
        put(OP_AND, 3'b010, 8'h00, y, 1);
        ac = ac & y;
        put(OP_XOR, 3'b010, 8'h00, x, 1);
        ac = ac ^ x;
        z = (ac == 8'h00);
        memop(OP_BSET, 3'b100, 8'h70, {5'h00, x[2:0]}, y,
              y | (8'h01 << x[2:0]), 1'b0);
        memop(OP_BCLR, 3'b101, 8'h71, {5'h00, y[2:0]}, x,
              x & ~(8'h01 << y[2:0]), 1'b0);
        memop(OP_XCH, 3'b100, 8'h72, 8'h00, m, ac, 1'b0);
        ac = m;
        memop(OP_RLC, 3'b000, 8'h73, 8'h00, m, {m[6:0], c}, 1'b0);
        c = m[7];
        wr(9'h087, x);
        put(OP_MOV, 3'b111, 8'h87, x, 1);
        put(OP_MOV, 3'b111, 8'h88, y, 1);
        put(OP_PUSH, 3'b000, 8'h00, 8'h00, 1);
        sv = ac;
        fl = {c, dc, z};
        put(OP_ADD, 3'b010, 8'h00, 8'h00 - ac, 1);
        put(OP_POP, 3'b000, 8'h00, 8'h00, 1);
        sto(1'b0, 8'hf0);
        put(OP_CALL, 3'b000, 8'h00, 8'hc0, 2);
        x = pcl;
        pcl = 8'hc0;
        sto(1'b0, 8'hf1);
        put(OP_RET, 3'b000, 8'h00, 8'h00, 2);
        pcl = x;
        put(OP_CALL, 3'b000, 8'h00, 8'hd0, 2);
        x = pcl;
        pcl = 8'hd0;
        put(OP_INTERRUPT_RETURN, 3'b000, 8'h00, 8'h00, 2);
        e_gie = 1'b1;
        pcl = x;
        sto(1'b0, 8'hf2);
        put(OP_JMP, 3'b000, 8'h00, pcl, 0);
        repeat (3) @(posedge i_clock);
        check({pc, mem_we, program_flag_register, gie}, {16'h0000, 1'b0, 8'h00, 1'b0});
        i_rst_b <= 1'b1;
        for (k = 0; k < 4000 && notes.size() != 0; k++) @(posedge i_clock);
        repeat (20) @(posedge i_clock);
        check(64'(notes.size()), 64'h0);
        check(64'(acc), 64'(ac));
        @(negedge i_clock);
        f0 = fetch;
        @(negedge i_clock);
        check(64'(fetch ^ f0), 64'h1);
        close_out();
    end
endmodule : mie_core_tb_top
